// ### include/shs_pkg.sv
/*
  shared types and constants for the shared hardware subdevice:
  delegated register port records, custom signal port records, serial
  frame layout and timing. assumes a 20 MHz control clock.
*/
package shs_pkg;

  // register access record widths
  localparam int RAW_ADDR_W = 8;
  localparam int RAW_DATA_W = 8;

  // serial frame: read flag, address, data, msb first
  localparam int FRAME_BITS  = 1 + RAW_ADDR_W + RAW_DATA_W;
  localparam int BIT_CNT_W   = 5;
  localparam int HALF_CNT_W  = 4;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS  = 250;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pin idle levels and read flag value
  localparam logic SCLK_IDLE = 1'b0;
  localparam logic CSN_IDLE  = 1'b1;
  localparam logic READ_FLAG = 1'b1;

  typedef struct packed {
    logic [RAW_ADDR_W-1:0] address;
    logic                  is_read;
    logic                  is_write;
    logic [RAW_DATA_W-1:0] data;
  } shs_rawreq_t;

  typedef struct packed {
    logic [RAW_DATA_W-1:0] data;
    logic                  done;
    logic                  error;
  } shs_rawresp_t;

  // device block to helper
  typedef struct packed {
    logic        present;
    logic        reset;
    shs_rawreq_t raw;
  } shs_rp_in_t;

  // helper to device block
  typedef struct packed {
    shs_rawresp_t raw;
  } shs_rp_out_t;

  // custom port, master outputs
  typedef struct packed {
    logic sync_req;
    logic enable;
  } shs_dev_m2s_t;

  // custom port, master inputs
  typedef struct packed {
    logic clk_p;
    logic clk_n;
  } shs_dev_s2m_t;

endpackage

// ### core/shs_serial.sv
/*
  serial engine of the shared control path: one frame per access,
  read flag, address and data msb first, three-wire with a shared
  data line. assumes sdi already synchronised by the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module shs_serial #(
  parameter int HALF_CYC = shs_pkg::SCLK_HALF_CYC
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            start,
  input  wire logic                            is_read,
  input  wire logic [shs_pkg::RAW_ADDR_W-1:0]  addr,
  input  wire logic [shs_pkg::RAW_DATA_W-1:0]  wdata,
  input  wire logic                            sdi,
  output logic                                 busy,
  output logic                                 done,
  output logic      [shs_pkg::RAW_DATA_W-1:0]  rdata,
  output logic                                 sclk,
  output logic                                 csn,
  output logic                                 sdo,
  output logic                                 sdo_oe
);

  typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_HIGH, SER_END}
    shs_ser_state_t;

  localparam logic [shs_pkg::HALF_CNT_W-1:0] HALF_LAST =
    shs_pkg::HALF_CNT_W'(HALF_CYC - 1);
  localparam logic [shs_pkg::BIT_CNT_W-1:0]  BITS_ALL  =
    shs_pkg::BIT_CNT_W'(shs_pkg::FRAME_BITS);
  localparam logic [shs_pkg::BIT_CNT_W-1:0]  BITS_DATA =
    shs_pkg::BIT_CNT_W'(shs_pkg::RAW_DATA_W);

  shs_ser_state_t                        state;
  logic [shs_pkg::HALF_CNT_W-1:0]        half_cnt;
  logic [shs_pkg::BIT_CNT_W-1:0]         bits_left;
  logic [shs_pkg::FRAME_BITS-1:0]        shreg;
  logic                                  rd;

  wire  half_done  = (half_cnt == HALF_LAST);
  wire  data_phase = (bits_left <= BITS_DATA);
  wire  in_frame   = (state == SER_LOW) || (state == SER_HIGH);

  assign busy   = (state != SER_IDLE);
  assign sdo    = shreg[shs_pkg::FRAME_BITS-1];
  // line released while the far device answers a read
  assign sdo_oe = in_frame && !(rd && data_phase);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= SER_IDLE;
      half_cnt  <= '0;
      bits_left <= '0;
      shreg     <= '0;
      rd        <= 1'b0;
      rdata     <= '0;
      done      <= 1'b0;
      sclk      <= shs_pkg::SCLK_IDLE;
      csn       <= shs_pkg::CSN_IDLE;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        SER_IDLE:
        begin
          if (start)
          begin
            shreg     <= {is_read, addr, wdata};
            rd        <= is_read;
            bits_left <= BITS_ALL;
            half_cnt  <= '0;
            csn       <= ~shs_pkg::CSN_IDLE;
            state     <= SER_LOW;
          end
        end
        SER_LOW:
        begin
          half_cnt <= half_done ? '0 : half_cnt + 1'b1;
          if (half_done)
          begin
            sclk  <= ~shs_pkg::SCLK_IDLE;
            state <= SER_HIGH;
          end
        end
        SER_HIGH:
        begin
          half_cnt <= half_done ? '0 : half_cnt + 1'b1;
          if (half_done)
          begin
            sclk      <= shs_pkg::SCLK_IDLE;
            shreg     <= {shreg[shs_pkg::FRAME_BITS-2:0], 1'b0};
            bits_left <= bits_left - 1'b1;
            if (rd && data_phase)
              rdata <= {rdata[shs_pkg::RAW_DATA_W-2:0], sdi};
            if (bits_left == 1)
            begin
              csn   <= shs_pkg::CSN_IDLE;
              state <= SER_END;
            end
            else
              state <= SER_LOW;
          end
        end
        default:
        begin
          done  <= 1'b1;
          state <= SER_IDLE;
        end
      endcase
    end
  end

endmodule // shs_serial

`default_nettype wire

// ### core/shs_shared_subdevice.sv
/*
  shared hardware subdevice: serves the delegated register ports of
  several device blocks one at a time over one shared serial control
  path, and merges their custom signal ports onto shared pins.
  assumes device blocks on the same CLOCK, strobing one-cycle requests.
*/
`timescale 1ns/1ps
`default_nettype none

module shs_shared_subdevice #(
  parameter int N_PORTS  = 2,
  parameter int HALF_CYC = shs_pkg::SCLK_HALF_CYC
) (
  input  wire logic                                CLOCK,
  input  wire logic                                RST_B,
  input  wire shs_pkg::shs_rp_in_t  [N_PORTS-1:0]  RAWPROP_IN,
  output var  shs_pkg::shs_rp_out_t [N_PORTS-1:0]  RAWPROP_OUT,
  input  wire shs_pkg::shs_dev_m2s_t [N_PORTS-1:0] DEV_IN,
  output var  shs_pkg::shs_dev_s2m_t [N_PORTS-1:0] DEV_OUT,
  input  wire logic                                DATA_CLK_P,
  input  wire logic                                DATA_CLK_N,
  output logic                                     SYNC_OUT,
  output logic                                     ENABLE_OUT,
  output logic                                     SCLK,
  output logic                                     CSN,
  output logic                                     SDIO_O,
  output logic                                     SDIO_OE,
  input  wire logic                                SDIO_I
);

  localparam int IDX_W = (N_PORTS > 1) ? $clog2(N_PORTS) : 1;

  typedef enum logic {ARB_IDLE, ARB_BUSY} shs_arb_state_t;

  // reset release
  logic rst_ff1;
  logic rst_n;

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_ff1 <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rst_ff1 <= 1'b1;
      rst_n   <= rst_ff1;
    end
  end

  // shared data line input, three stages
  logic sdi_s1;
  logic sdi_s2;
  logic sdi_s3;
  logic sdi;

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      sdi_s3 <= 1'b0;
      sdi    <= 1'b0;
    end
    else
    begin
      sdi_s1 <= SDIO_I;
      sdi_s2 <= sdi_s1;
      sdi_s3 <= sdi_s2;
      if (sdi_s2 == sdi_s3)
        sdi <= sdi_s3;
    end
  end

  // per-port request capture
  logic                 [N_PORTS-1:0] live;
  logic                 [N_PORTS-1:0] strobe;
  logic                 [N_PORTS-1:0] grant_clr;
  logic                 [N_PORTS-1:0] pending;
  logic                 [N_PORTS-1:0] resp_done;
  shs_pkg::shs_rawreq_t [N_PORTS-1:0] req_hold;
  logic                 [N_PORTS-1:0] dev_sync;
  logic                 [N_PORTS-1:0] dev_en;

  logic                                arb_idle;
  logic                                have_pick;
  logic      [IDX_W-1:0]               pick;
  logic      [IDX_W-1:0]               owner;
  logic                                resp_err;
  logic      [shs_pkg::RAW_DATA_W-1:0] resp_data;
  shs_arb_state_t                      arb_state;

  genvar g;
  generate
    for (g = 0; g < N_PORTS; g++)
    begin : g_port
      // absent or resetting blocks raise no register requests; their custom signals still merge
      assign live[g]      = RAWPROP_IN[g].present
                            && !RAWPROP_IN[g].reset;
      assign strobe[g]    = live[g] && (RAWPROP_IN[g].raw.is_read
                            || RAWPROP_IN[g].raw.is_write);
      assign grant_clr[g] = arb_idle && have_pick
                            && (pick == IDX_W'(g));

      always_ff @(posedge CLOCK or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pending[g]  <= 1'b0;
          req_hold[g] <= '0;
        end
        else
        begin
          // a new strobe beats the grant that clears
          pending[g] <= live[g]
                        && ((pending[g] && !grant_clr[g]) || strobe[g]);
          if (strobe[g])
            req_hold[g] <= RAWPROP_IN[g].raw;
        end
      end

      assign RAWPROP_OUT[g].raw.data  = resp_data;
      assign RAWPROP_OUT[g].raw.done  = resp_done[g];
      assign RAWPROP_OUT[g].raw.error = resp_err;

      assign dev_sync[g] = DEV_IN[g].sync_req;
      assign dev_en[g]   = DEV_IN[g].enable;
      // sample clock fanned out unsampled, it is a clock
      assign DEV_OUT[g].clk_p = DATA_CLK_P;
      assign DEV_OUT[g].clk_n = DATA_CLK_N;
    end
  endgenerate

  // round robin pick, starting after the last owner
  always_comb
  begin
    logic [IDX_W:0] idx;
    have_pick = 1'b0;
    pick      = '0;
    idx       = '0;
    for (int k = N_PORTS; k >= 1; k--)
    begin
      idx = (IDX_W+1)'((int'(owner) + k) % N_PORTS);
      if (pending[idx[IDX_W-1:0]])
      begin
        have_pick = 1'b1;
        pick      = idx[IDX_W-1:0];
      end
    end
  end

  wire shs_pkg::shs_rawreq_t sel_req = req_hold[pick];
  wire sel_bad   = sel_req.is_read && sel_req.is_write;
  wire eng_start = arb_idle && have_pick && !sel_bad;
  wire eng_done;
  wire [shs_pkg::RAW_DATA_W-1:0] eng_rdata;

  assign arb_idle = (arb_state == ARB_IDLE);

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arb_state <= ARB_IDLE;
      owner     <= IDX_W'(N_PORTS - 1);
      resp_done <= '0;
      resp_err  <= 1'b0;
      resp_data <= '0;
    end
    else
    begin
      resp_done <= '0;
      case (arb_state)
        ARB_IDLE:
        begin
          if (have_pick)
          begin
            owner <= pick;
            if (sel_bad)
            begin
              // both strobes at once is refused at once
              resp_done[pick] <= 1'b1;
              resp_err        <= 1'b1;
            end
            else
              arb_state <= ARB_BUSY;
          end
        end
        default:
        begin
          if (eng_done)
          begin
            arb_state <= ARB_IDLE;
            resp_err  <= 1'b0;
            resp_data <= eng_rdata;
            // owner reset mid-access gets no answer
            resp_done[owner] <= live[owner];
          end
        end
      endcase
    end
  end

  // merged custom outputs onto the shared pins
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SYNC_OUT   <= 1'b0;
      ENABLE_OUT <= 1'b0;
    end
    else
    begin
      SYNC_OUT   <= |dev_sync;
      ENABLE_OUT <= |dev_en;
    end
  end

  // sole owner of the serial pins
  shs_serial #(
    .HALF_CYC (HALF_CYC)
  ) u_serial (
    .clk     (CLOCK),
    .rst_n   (rst_n),
    .start   (eng_start),
    .is_read (sel_req.is_read),
    .addr    (sel_req.address),
    .wdata   (sel_req.data),
    .sdi     (sdi),
    .busy    (),
    .done    (eng_done),
    .rdata   (eng_rdata),
    .sclk    (SCLK),
    .csn     (CSN),
    .sdo     (SDIO_O),
    .sdo_oe  (SDIO_OE)
  );

endmodule // shs_shared_subdevice

`default_nettype wire

// ### verification/shs_properties.sv
/*
  port checker for the shared subdevice.
  assumes the bind at the foot and the design's 20 MHz CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none

module shs_properties #(
  parameter int N_PORTS = 2
) (
  input wire logic                                CLOCK,
  input wire logic                                RST_B,
  input wire shs_pkg::shs_rp_out_t  [N_PORTS-1:0] RAWPROP_OUT,
  input wire shs_pkg::shs_dev_m2s_t [N_PORTS-1:0] DEV_IN,
  input wire shs_pkg::shs_dev_s2m_t [N_PORTS-1:0] DEV_OUT,
  input wire logic                                DATA_CLK_P,
  input wire logic                                DATA_CLK_N,
  input wire logic                                SYNC_OUT,
  input wire logic                                ENABLE_OUT,
  input wire logic                                SCLK,
  input wire logic                                CSN,
  input wire logic                                SDIO_OE
);
  logic [N_PORTS-1:0] done;
  logic               any_sync;
  logic               any_en;
  logic [1:0]         age;

  always_comb
  begin
    any_sync = 1'b0;
    any_en = 1'b0;
    for (int i = 0; i < N_PORTS; i++)
    begin
      done[i] = RAWPROP_OUT[i].raw.done;
      any_sync = any_sync | DEV_IN[i].sync_req;
      any_en = any_en | DEV_IN[i].enable;
    end
  end

  // edges since reset release, saturating
  always_ff @(posedge CLOCK or negedge RST_B)
    if (!RST_B)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  one_owner_a: assert property (
    $onehot0(done)) else $error("two ports answered together");
  done_pulse_a: assert property (
    done[0] |=> !done[0]) else $error("done longer than one cycle");
  error_done_a: assert property (
    $rose(RAWPROP_OUT[0].raw.error) |-> (|done))
    else $error("error rose without done");
  sync_merge_a: assert property (
    age == 2'h3 |-> SYNC_OUT == $past(any_sync))
    else $error("sync merge wrong");
  enable_merge_a: assert property (
    age == 2'h3 |-> ENABLE_OUT == $past(any_en))
    else $error("enable merge wrong");
  clk_fwd_a: assert property (
    DEV_OUT == {N_PORTS{DATA_CLK_P, DATA_CLK_N}})
    else $error("sample clock not forwarded");
  frame_hold_a: assert property (
    $fell(CSN) |=> !CSN [*8]) else $error("frame ended early");
  pins_in_frame_a: assert property (
    (SCLK || SDIO_OE) |-> !CSN) else $error("pin active outside frame");
  frame_answer_a: assert property (
    $rose(CSN) |-> ##[1:3] (|done)) else $error("no answer after frame");
endmodule // shs_properties

bind shs_shared_subdevice shs_properties #(.N_PORTS(N_PORTS))
  u_shs_properties (
  .CLOCK(CLOCK), .RST_B(RST_B), .RAWPROP_OUT(RAWPROP_OUT), .DEV_IN(DEV_IN),
  .DEV_OUT(DEV_OUT), .DATA_CLK_P(DATA_CLK_P), .DATA_CLK_N(DATA_CLK_N),
  .SYNC_OUT(SYNC_OUT), .ENABLE_OUT(ENABLE_OUT), .SCLK(SCLK), .CSN(CSN),
  .SDIO_OE(SDIO_OE)
);

`default_nettype wire

// ### verification/shs_peer_model.sv
/*
  serial register device on the shared control path.
  assumes frames of read flag, address, data, msb first.
*/
`timescale 1ns/1ps
`default_nettype none

module shs_peer_model (
  input  wire logic        SCLK,
  input  wire logic        CSN,
  input  wire logic        SDIO_O,
  input  wire logic        SDIO_OE,
  output logic             SDIO_I,
  output logic [16:0]      frame
);
  logic [7:0] mem [256];
  logic [7:0] rd;
  logic [4:0] cnt;
  logic       bit_v = 1'b0;

  initial
    foreach (mem[i])
      mem[i] = 8'h00;
  // released line shows the read bit, and between frames the inverse of the last bit
  assign SDIO_I = SDIO_OE ? SDIO_O : bit_v;

  always @(negedge CSN)
    cnt = 5'h00;
  always @(posedge CSN)
    bit_v = ~bit_v;
  always @(posedge SCLK)
  begin
    frame = {frame[15:0], SDIO_I};
    cnt = cnt + 5'h01;
    if (cnt == 5'd17 && !frame[16])
      mem[frame[15:8]] = frame[7:0];
  end
  // read bit set up in the low phase, held through high
  always @(negedge SCLK)
  begin
    if (cnt == 5'd9)
      rd = mem[frame[7:0]];
    if (!CSN && cnt >= 5'd9 && cnt < 5'd17 && frame[cnt-5'd9+5'd8])
      bit_v = rd[5'd16-cnt];
  end
endmodule // shs_peer_model

`default_nettype wire

// ### verification/shs_shared_subdevice_bench.sv
/*
  self-checking bench for the shared subdevice.
  assumes shs_peer_model on the serial pins and HALF_CYC of 4.
*/
`timescale 1ns/1ps
`default_nettype none

module shs_shared_subdevice_bench;
  localparam int NP = 2;
  shs_pkg::shs_rp_in_t   [NP-1:0] rp_in;
  shs_pkg::shs_rp_out_t  [NP-1:0] rp_out;
  shs_pkg::shs_dev_m2s_t [NP-1:0] dev_in;
  shs_pkg::shs_dev_s2m_t [NP-1:0] dev_out;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic clk_p, clk_n, sync_o, en_o, sclk, csn, sdo, sdo_oe, sdi;
  logic [16:0] frame;
  logic [7:0]  a, d, d2;
  logic [10:0] expq[$]; // port, error, data checked, data
  int n_mismatch = 0;
  int comparisons = 0;

  always #25 CLOCK = ~CLOCK;

  shs_shared_subdevice #(.N_PORTS(NP), .HALF_CYC(4)) u_shs_shared_subdevice (
    .CLOCK(CLOCK), .RST_B(RST_B), .RAWPROP_IN(rp_in), .RAWPROP_OUT(rp_out),
    .DEV_IN(dev_in), .DEV_OUT(dev_out), .DATA_CLK_P(clk_p),
    .DATA_CLK_N(clk_n), .SYNC_OUT(sync_o), .ENABLE_OUT(en_o), .SCLK(sclk),
    .CSN(csn), .SDIO_O(sdo), .SDIO_OE(sdo_oe), .SDIO_I(sdi));
  shs_peer_model u_shs_peer_model (.SCLK(sclk), .CSN(csn), .SDIO_O(sdo),
    .SDIO_OE(sdo_oe), .SDIO_I(sdi), .frame(frame));

  task automatic check(string what, logic [16:0] exp, logic [16:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // answers compared in the order they were expected
  always @(posedge CLOCK)
    for (int i = 0; i < NP; i++)
      if (rp_out[i].raw.done !== 1'b0)
      begin
        if (expq.size() == 0)
          check("unexpected done", 17'(NP), 17'(i));
        else
        begin
          logic [10:0] e;
          e = expq.pop_front();
          check("done port", 17'(e[10]), 17'(i));
          check("error", 17'(e[9]), 17'(rp_out[i].raw.error));
          if (e[8])
            check("read data", 17'(e[7:0]),
              17'(rp_out[i].raw.data));
        end
      end

  // one-cycle strobe on one port, fields sampled with it
  task automatic strobe(int p, logic rd, logic wr, logic [7:0] ad, dd);
    rp_in[p].raw.address = ad;
    rp_in[p].raw.data = dd;
    rp_in[p].raw.is_read = rd;
    rp_in[p].raw.is_write = wr;
  endtask

  task automatic go(int cycles);
    @(negedge CLOCK);
    for (int i = 0; i < NP; i++)
      strobe(i, 1'b0, 1'b0, rp_in[i].raw.address, rp_in[i].raw.data);
    for (int i = 0; i < 600 && (expq.size() > 0 || i < cycles); i++)
      @(negedge CLOCK);
    if (expq.size() > 0)
    begin
      check("answer wait", 17'h0, 17'h1);
      conclude();
    end
  endtask

  initial
  begin
    rp_in = '0;
    dev_in = '0;
    clk_p = 1'b0;
    clk_n = 1'b1;
    void'($urandom(35280));
    for (int i = 0; i < NP; i++)
      rp_in[i].present = 1'b1;
    repeat (16) @(negedge CLOCK);
    RST_B = 1'b1;
    repeat (4) @(negedge CLOCK);
    for (int k = 0; k < 4; k++)
    begin
      a = 8'($urandom);
      d = 8'($urandom);
      strobe(k % 2, 1'b0, 1'b1, a, d);
      expq.push_back({1'(k % 2), 2'b00, d});
      go(0);
      check("write frame", {1'b0, a, d}, frame);
      strobe(1 - k % 2, 1'b1, 1'b0, a, 8'h00);
      expq.push_back({1'(1 - k % 2), 2'b01, d});
      go(0);
    end
    // last owner port 0, so port 1 goes first
    d2 = ~d;
    strobe(0, 1'b0, 1'b1, a, d2);
    strobe(1, 1'b1, 1'b0, a, 8'h00);
    expq.push_back({1'b1, 2'b01, d});
    expq.push_back({1'b0, 2'b00, d});
    go(0);
    strobe(0, 1'b1, 1'b1, a, 8'h00);
    expq.push_back({1'b0, 2'b10, 8'h00});
    go(0);
    rp_in[1].present = 1'b0;
    strobe(1, 1'b0, 1'b1, a, 8'h00);
    go(200);
    rp_in[1].present = 1'b1;
    rp_in[1].reset = 1'b1;
    strobe(1, 1'b0, 1'b1, a, 8'h00);
    go(200);
    rp_in[1].reset = 1'b0;
    strobe(1, 1'b1, 1'b0, a, 8'h00);
    expq.push_back({1'b1, 2'b01, d2});
    go(0);
    // port 1 queued behind port 0, then reset: its request is dropped
    strobe(0, 1'b1, 1'b0, a, 8'h00);
    strobe(1, 1'b0, 1'b1, a, d);
    expq.push_back({1'b0, 2'b01, d2});
    @(negedge CLOCK);
    rp_in[0].raw.is_read = 1'b0;
    rp_in[1].raw.is_write = 1'b0;
    rp_in[1].reset = 1'b1;
    go(200);
    rp_in[1].reset = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      dev_in = 4'($urandom);
      {clk_p, clk_n} = 2'($urandom);
      repeat (2) @(negedge CLOCK);
      check("sync out", 17'(dev_in[0].sync_req | dev_in[1].sync_req),
        17'(sync_o));
      check("enable out", 17'(dev_in[0].enable | dev_in[1].enable),
        17'(en_o));
      check("clock fwd", 17'({NP{clk_p, clk_n}}), 17'(dev_out));
    end
    conclude();
  end
endmodule // shs_shared_subdevice_bench

`default_nettype wire
